/* sac_defines.vh */
`ifndef SAC_DEFINES_VH
`define SAC_DEFINES_VH
// register byte offsets
`define SAC_OFS_CTRL 8'h00
`define SAC_OFS_CFG 8'h04
`define SAC_OFS_ACC 8'h08
`define SAC_OFS_RESULT 8'h0C
`define SAC_OFS_GT 8'h10
`define SAC_OFS_LT 8'h14
`define SAC_OFS_TIMING 8'h18
// control fields
`define SAC_CTRL_EN 7
`define SAC_CTRL_BURST 6
`define SAC_CTRL_DONE 5
`define SAC_CTRL_BUSY 4
`define SAC_CTRL_WIN 3
`define SAC_CTRL_LPTRK 8
// config fields
`define SAC_CFG_GAIN 0
`define SAC_CFG_EIGHT 2
`define SAC_CFG_DIV_LSB 3
// accumulator config fields
`define SAC_ACC_TWELVE 7
// start sources
`define SAC_SRC_SW 3'h0
`define SAC_SRC_T0 3'h1
`define SAC_SRC_T2 3'h2
`define SAC_SRC_T3 3'h3
// timing
`define SAC_LPTRK_CLKS 8'h03
`define SAC_BITS_10 4'h0A
`define SAC_BITS_8 4'h08
`define SAC_RESP_OKAY 2'h0
`define SAC_RESP_SLVERR 2'h2
`endif

/* sac_sar_core.v */
`timescale 1ns/10ps
`include "sac_defines.vh"
// one successive-approximation conversion against the analog comparator
module sac_sar_core #(
    parameter W = 10
) (
    input wire i_clk,
    input wire i_rst,
    input wire i_sar_tick,
    input wire i_go,
    input wire i_eight,
    input wire [1:0] i_step,
    input wire i_cmp,
    output reg [W-1:0] o_trial,
    output reg [1:0] o_dem_phase,
    output reg o_busy,
    output reg o_done,
    output reg [W-1:0] o_code
);
    localparam [3:0] TOP_BIT = W - 1;
    reg [3:0] bit_q;
    reg [3:0] last_q;
    // the trial reaches the comparator through the top's output register,
    // so a tick right after a trial change would read a stale comparator
    reg hold_q;
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_trial <= {W{1'b0}};
            o_dem_phase <= 2'h0;
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_code <= {W{1'b0}};
            bit_q <= 4'h0;
            last_q <= 4'h0;
            hold_q <= 1'b0;
        end else begin
            o_done <= 1'b0;
            hold_q <= 1'b0;
            if (i_go && !o_busy) begin
                o_busy <= 1'b1;
                hold_q <= 1'b1;
                bit_q <= TOP_BIT;
                // eight-bit runs stop two bits early, two fewer sar clocks
                last_q <= i_eight ? 4'h2 : 4'h0;
                o_trial <= {1'b1, {(W-1){1'b0}}};
                o_dem_phase <= i_step;
            end else if (o_busy && i_sar_tick && !hold_q) begin
                hold_q <= 1'b1;
                if (!i_cmp) begin
                    o_trial[bit_q] <= 1'b0;
                end
                if (bit_q == last_q) begin
                    o_busy <= 1'b0;
                    o_done <= 1'b1;
                    o_code <= i_cmp ? o_trial : (o_trial & ~({{(W-1){1'b0}}, 1'b1} << bit_q));
                end else begin
                    bit_q <= bit_q - 4'h1;
                    o_trial[bit_q - 4'h1] <= 1'b1;
                end
            end
        end
    end
endmodule // sac_sar_core

/* sac_top.v */
`timescale 1ns/10ps
`include "sac_defines.vh"
// Contract
// - start from selected source event
// - source field decodes sw, t0, t2, t3, pin
// - busy high during conversion, low after
// - busy falling edge after the final conversion of a series sets done flag
// - hardware sets done; software clears it
// - result valid whenever done reads one
// - timer byte overflow chosen by timer width
// - normal mode tracks except while converting
// - low-power tracking adds three sar clocks
// - pin source tracks low, converts on rise
// - burst mode runs repeat count conversions
// - enable bit picks idle power in burst
// - powered-down converter waits power-up time in burst
// - burst one start; else start per conversion
// - done only after full repeat count
// - window compare only on final sum
// - burst tracking from fields, plus three with low-power tracking
// - gain bit selects one or half gain
// - eight-bit mode, low bits zero
// - twelve-bit: four conversions, or the repeat count if larger, rotated elements
// - twelve-bit enable with burst four
// - twelve-bit max 4092 at repeat count four, multiples of four
module sac_top (
    input wire I_CLK,
    input wire I_SYS_RST,
    input wire [7:0] I_AWADDR,
    input wire I_AWVALID,
    output reg O_AWREADY,
    input wire [31:0] I_WDATA,
    input wire [3:0] I_WSTRB,
    input wire I_WVALID,
    output reg O_WREADY,
    output reg [1:0] O_BRESP,
    output reg O_BVALID,
    input wire I_BREADY,
    input wire [7:0] I_ARADDR,
    input wire I_ARVALID,
    output reg O_ARREADY,
    output reg [31:0] O_RDATA,
    output reg [1:0] O_RRESP,
    output reg O_RVALID,
    input wire I_RREADY,
    input wire I_T0_OVF,
    input wire I_T2_LO_OVF,
    input wire I_T2_HI_OVF,
    input wire I_T2_16BIT,
    input wire I_T3_LO_OVF,
    input wire I_T3_HI_OVF,
    input wire I_T3_16BIT,
    input wire I_EXTERNAL_CONVERT_START,
    input wire I_BURST_TICK,
    input wire I_CMP,
    output reg [9:0] O_DAC_TRIAL,
    output reg [1:0] O_DEM_PHASE,
    output reg O_TRACK,
    output reg O_POWER_ON,
    output reg O_GAIN_HALF,
    output reg O_SAR_BUSY
);
    localparam S_IDLE = 5'h01;
    localparam S_PWRUP = 5'h02;
    localparam S_TRACK = 5'h04;
    localparam S_CONV = 5'h08;
    localparam S_DONE = 5'h10;

    reg [8:0] ctrl_q;
    reg [7:0] cfg_q;
    reg [7:0] acc_cfg_q;
    reg [15:0] gt_q;
    reg [15:0] lt_q;
    reg [15:0] timing_q;
    reg [15:0] result_q;
    reg [15:0] accum_q;
    reg [4:0] state_q;
    reg [6:0] count_q;
    reg [7:0] wait_q;
    reg [1:0] step_q;
    reg [7:0] div_q;
    reg pin_q;
    reg busy_q;
    reg go_q;
    reg sw_start_q;
    reg [31:0] rdata_d;
    reg [6:0] target;
    wire conv_busy;
    wire conv_done;
    wire [9:0] conv_code;
    wire [9:0] trial;
    wire [1:0] dem;
    wire burst = ctrl_q[`SAC_CTRL_BURST];
    wire lptrk = ctrl_q[`SAC_CTRL_LPTRK];
    wire twelve = acc_cfg_q[`SAC_ACC_TWELVE];
    wire eight = cfg_q[`SAC_CFG_EIGHT];
    wire [2:0] src = ctrl_q[2:0];
    wire pin_rise = I_EXTERNAL_CONVERT_START && !pin_q;
    wire sar_tick = burst ? I_BURST_TICK : (div_q == 8'h00);
    wire t2_ovf = I_T2_16BIT ? I_T2_HI_OVF : I_T2_LO_OVF;
    wire t3_ovf = I_T3_16BIT ? I_T3_HI_OVF : I_T3_LO_OVF;
    reg start_ev;
    wire do_wr = I_AWVALID && I_WVALID && !O_BVALID;
    wire do_rd = I_ARVALID && !O_RVALID;
    wire wr_ctrl = do_wr && I_AWADDR == `SAC_OFS_CTRL && I_WSTRB[0];
    wire series_end = (state_q == S_DONE);

    always @* begin
        start_ev = 1'b0;
        case (src)
            `SAC_SRC_SW: start_ev = sw_start_q;
            `SAC_SRC_T0: start_ev = I_T0_OVF;
            `SAC_SRC_T2: start_ev = t2_ovf;
            `SAC_SRC_T3: start_ev = t3_ovf;
            default: start_ev = pin_rise;
        endcase
    end

    // repeat count 1,4,8..64 from field, twelve-bit forces a multiple of four
    always @* begin
        case (acc_cfg_q[2:0])
            3'h0: target = 7'h01;
            3'h1: target = 7'h04;
            3'h2: target = 7'h08;
            3'h3: target = 7'h10;
            3'h4: target = 7'h20;
            default: target = 7'h40;
        endcase
        if (twelve && target == 7'h01) begin
            target = 7'h04;
        end
    end

    sac_sar_core #(.W(10)) u_core (
        .i_clk(I_CLK),
        .i_rst(I_SYS_RST),
        .i_sar_tick(sar_tick),
        .i_go(go_q),
        .i_eight(eight && !twelve),
        .i_step(step_q),
        .i_cmp(I_CMP),
        .o_trial(trial),
        .o_dem_phase(dem),
        .o_busy(conv_busy),
        .o_done(conv_done),
        .o_code(conv_code)
    );

    always @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            state_q <= S_IDLE;
            count_q <= 7'h00;
            wait_q <= 8'h00;
            step_q <= 2'h0;
            accum_q <= 16'h0000;
            result_q <= 16'h0000;
            busy_q <= 1'b0;
            go_q <= 1'b0;
            div_q <= 8'h00;
            pin_q <= 1'b0;
        end else begin
            pin_q <= I_EXTERNAL_CONVERT_START;
            // divider runs free, so the first sar tick of a conversion may come early
            div_q <= (div_q == {3'h0, cfg_q[7:`SAC_CFG_DIV_LSB]}) ? 8'h00 : div_q + 8'h01;
            go_q <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (start_ev) begin
                        busy_q <= 1'b1;
                        if (count_q == 7'h00) begin
                            accum_q <= 16'h0000;
                        end
                        if (burst && !ctrl_q[`SAC_CTRL_EN]) begin
                            wait_q <= timing_q[7:0];
                            state_q <= S_PWRUP;
                        end else begin
                            wait_q <= (burst ? timing_q[15:8] : 8'h00)
                                + (lptrk ? `SAC_LPTRK_CLKS : 8'h00);
                            state_q <= S_TRACK;
                        end
                    end
                end
                S_PWRUP: begin
                    if (sar_tick) begin
                        if (wait_q == 8'h00) begin
                            wait_q <= timing_q[15:8] + (lptrk ? `SAC_LPTRK_CLKS : 8'h00);
                            state_q <= S_TRACK;
                        end else begin
                            wait_q <= wait_q - 8'h01;
                        end
                    end
                end
                S_TRACK: begin
                    if (wait_q == 8'h00) begin
                        go_q <= 1'b1;
                        state_q <= S_CONV;
                    end else if (sar_tick) begin
                        wait_q <= wait_q - 8'h01;
                    end
                end
                S_CONV: begin
                    if (conv_done) begin
                        accum_q <= accum_q + {6'h00, conv_code};
                        step_q <= twelve ? step_q + 2'h1 : 2'h0;
                        if (count_q + 7'h01 >= target) begin
                            count_q <= 7'h00;
                            state_q <= S_DONE;
                        end else begin
                            count_q <= count_q + 7'h01;
                            if (burst) begin
                                // burst keeps going from one start
                                wait_q <= timing_q[15:8] + (lptrk ? `SAC_LPTRK_CLKS : 8'h00);
                                state_q <= S_TRACK;
                            end else begin
                                busy_q <= 1'b0;
                                state_q <= S_IDLE;
                            end
                        end
                    end
                end
                S_DONE: begin
                    // eight-bit code sits in the high byte; sums of several codes overflow it
                    result_q <= eight && !twelve ? {accum_q[9:2], 8'h00} : accum_q;
                    busy_q <= 1'b0;
                    step_q <= 2'h0;
                    state_q <= S_IDLE;
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // flags and register writes; hardware set beats software clear
    always @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            ctrl_q <= 9'h000;
            cfg_q <= 8'h00;
            acc_cfg_q <= 8'h00;
            gt_q <= 16'hFFFF;
            lt_q <= 16'h0000;
            timing_q <= 16'h0000;
            sw_start_q <= 1'b0;
        end else begin
            sw_start_q <= wr_ctrl && I_WDATA[`SAC_CTRL_BUSY] && src == `SAC_SRC_SW;
            if (do_wr) begin
                case (I_AWADDR)
                    `SAC_OFS_CTRL: begin
                        if (I_WSTRB[0]) begin
                            ctrl_q[7:6] <= I_WDATA[7:6];
                            ctrl_q[2:0] <= I_WDATA[2:0];
                            if (!I_WDATA[`SAC_CTRL_DONE]) begin
                                ctrl_q[`SAC_CTRL_DONE] <= 1'b0;
                            end
                            if (!I_WDATA[`SAC_CTRL_WIN]) begin
                                ctrl_q[`SAC_CTRL_WIN] <= 1'b0;
                            end
                        end
                        if (I_WSTRB[1]) begin
                            ctrl_q[8] <= I_WDATA[8];
                        end
                    end
                    `SAC_OFS_CFG: if (I_WSTRB[0]) cfg_q <= I_WDATA[7:0];
                    `SAC_OFS_ACC: if (I_WSTRB[0]) acc_cfg_q <= I_WDATA[7:0];
                    `SAC_OFS_GT: gt_q <= I_WDATA[15:0];
                    `SAC_OFS_LT: lt_q <= I_WDATA[15:0];
                    `SAC_OFS_TIMING: timing_q <= I_WDATA[15:0];
                    default: ;
                endcase
            end
            if (series_end) begin
                ctrl_q[`SAC_CTRL_DONE] <= 1'b1;
                if (accum_q >= gt_q && accum_q <= lt_q) begin
                    ctrl_q[`SAC_CTRL_WIN] <= 1'b1;
                end
            end
        end
    end

    always @* begin
        rdata_d = 32'h0000_0000;
        case (I_ARADDR)
            `SAC_OFS_CTRL: rdata_d = {23'h00_0000, ctrl_q[8:5], busy_q, ctrl_q[3:0]};
            `SAC_OFS_CFG: rdata_d = {24'h00_0000, cfg_q};
            `SAC_OFS_ACC: rdata_d = {24'h00_0000, acc_cfg_q};
            `SAC_OFS_RESULT: rdata_d = {16'h0000, result_q};
            `SAC_OFS_GT: rdata_d = {16'h0000, gt_q};
            `SAC_OFS_LT: rdata_d = {16'h0000, lt_q};
            `SAC_OFS_TIMING: rdata_d = {16'h0000, timing_q};
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            O_AWREADY <= 1'b0;
            O_WREADY <= 1'b0;
            O_BVALID <= 1'b0;
            O_BRESP <= `SAC_RESP_OKAY;
            O_ARREADY <= 1'b0;
            O_RVALID <= 1'b0;
            O_RDATA <= 32'h0000_0000;
            O_RRESP <= `SAC_RESP_OKAY;
            O_DAC_TRIAL <= 10'h000;
            O_DEM_PHASE <= 2'h0;
            O_TRACK <= 1'b0;
            O_POWER_ON <= 1'b0;
            O_GAIN_HALF <= 1'b0;
            O_SAR_BUSY <= 1'b0;
        end else begin
            O_AWREADY <= do_wr && !O_AWREADY;
            O_WREADY <= do_wr && !O_WREADY;
            if (do_wr && !O_AWREADY) begin
                O_BVALID <= 1'b1;
                O_BRESP <= (I_AWADDR == `SAC_OFS_RESULT || I_AWADDR > `SAC_OFS_TIMING
                    || I_AWADDR[1:0] != 2'h0) ? `SAC_RESP_SLVERR : `SAC_RESP_OKAY;
            end else if (I_BREADY) begin
                O_BVALID <= 1'b0;
            end
            O_ARREADY <= do_rd && !O_ARREADY;
            if (do_rd && !O_ARREADY) begin
                O_RVALID <= 1'b1;
                O_RDATA <= rdata_d;
                O_RRESP <= (I_ARADDR > `SAC_OFS_TIMING || I_ARADDR[1:0] != 2'h0)
                    ? `SAC_RESP_SLVERR : `SAC_RESP_OKAY;
            end else if (I_RREADY) begin
                O_RVALID <= 1'b0;
            end
            O_DAC_TRIAL <= trial;
            O_DEM_PHASE <= dem;
            // normal mode tracks whenever not converting
            O_TRACK <= (state_q == S_TRACK) || (!burst && !lptrk && !conv_busy)
                || (lptrk && !burst && src[2] && !I_EXTERNAL_CONVERT_START);
            O_POWER_ON <= burst ? (ctrl_q[`SAC_CTRL_EN] || state_q != S_IDLE)
                : ctrl_q[`SAC_CTRL_EN];
            O_GAIN_HALF <= !cfg_q[`SAC_CFG_GAIN];
            O_SAR_BUSY <= busy_q;
        end
    end
endmodule // sac_top

/* sac_checker_properties.sv */
`timescale 1ns/10ps
module sac_checker (
    input wire I_CLK,
    input wire I_SYS_RST,
    input wire I_AWVALID,
    input wire I_WVALID,
    input wire I_ARVALID,
    input wire I_BREADY,
    input wire I_RREADY,
    input wire O_AWREADY,
    input wire O_WREADY,
    input wire O_ARREADY,
    input wire O_BVALID,
    input wire O_RVALID,
    input wire [9:0] O_DAC_TRIAL,
    input wire [1:0] O_DEM_PHASE,
    input wire O_POWER_ON,
    input wire O_GAIN_HALF,
    input wire O_SAR_BUSY
);
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_SYS_RST);
    chk_write_answer: assert property (I_AWVALID && I_WVALID && !O_BVALID && !O_AWREADY
        |=> O_AWREADY && O_BVALID) else $error("write not answered");
    chk_read_answer: assert property (I_ARVALID && !O_RVALID && !O_ARREADY
        |=> O_ARREADY && O_RVALID) else $error("read not answered");
    chk_aw_pulse: assert property (O_AWREADY |=> !O_AWREADY) else $error("awready held");
    chk_aw_w_pair: assert property (O_AWREADY == O_WREADY) else $error("aw and w split");
    chk_ar_with_r: assert property (O_ARREADY |-> O_RVALID) else $error("arready alone");
    chk_b_release: assert property (O_BVALID && I_BREADY |=> !O_BVALID)
        else $error("bvalid after handshake");
    chk_r_release: assert property (O_RVALID && I_RREADY |=> !O_RVALID)
        else $error("rvalid after handshake");
    // the trial code may only move while a conversion runs or just ended
    chk_trial_idle: assert property ($changed(O_DAC_TRIAL) |-> O_SAR_BUSY
        || $past(O_SAR_BUSY)) else $error("trial moved while idle");
    chk_gain_cause: assert property ($changed(O_GAIN_HALF) |-> O_AWREADY || $past(O_AWREADY)
        || $past(I_SYS_RST) || $past(I_SYS_RST, 2)) else $error("gain moved unasked");
    // element rotation is loaded only when a conversion is launched
    chk_dem_move: assert property ($changed(O_DEM_PHASE) |-> O_SAR_BUSY
        || $past(O_SAR_BUSY)) else $error("phase moved while idle");
    cover property ($fell(O_SAR_BUSY));
    cover property ($rose(O_POWER_ON));
    cover property (O_DEM_PHASE == 2'h3);
endmodule // sac_checker

/* sac_analog_model.sv */
`timescale 1ns/10ps
module sac_analog_model (
    input wire i_clk,
    input wire i_burst_on,
    input wire [9:0] i_level,
    input wire [9:0] i_trial,
    output wire o_cmp,
    output reg o_tick
);
    reg [1:0] div_q = 2'h0;
    assign o_cmp = (i_level >= i_trial);
    // burst oscillator is free of the bus timing; it only ticks while burst is on
    always @(posedge i_clk) begin
        div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
        o_tick <= i_burst_on && (div_q == 2'h0);
    end
endmodule // sac_analog_model

/* sac_top_tb.sv */
`timescale 1ns/10ps
`include "sac_defines.vh"
bind sac_top sac_checker u_chk (
    .I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_AWVALID(I_AWVALID), .I_WVALID(I_WVALID),
    .I_ARVALID(I_ARVALID), .I_BREADY(I_BREADY), .I_RREADY(I_RREADY), .O_AWREADY(O_AWREADY),
    .O_WREADY(O_WREADY), .O_ARREADY(O_ARREADY), .O_BVALID(O_BVALID), .O_RVALID(O_RVALID),
    .O_DAC_TRIAL(O_DAC_TRIAL), .O_DEM_PHASE(O_DEM_PHASE), .O_POWER_ON(O_POWER_ON),
    .O_GAIN_HALF(O_GAIN_HALF), .O_SAR_BUSY(O_SAR_BUSY)
);
module sac_top_tb;
    localparam [7:0] CT = `SAC_OFS_CTRL;
    localparam [7:0] CF = `SAC_OFS_CFG;
    localparam [7:0] AC = `SAC_OFS_ACC;
    localparam [1:0] OK = `SAC_RESP_OKAY;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg [7:0] awaddr = 8'h00;
    reg [7:0] araddr = 8'h00;
    reg [31:0] wdata = 32'h0000_0000;
    reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    reg t0 = 0, t2l = 0, t2h = 0, t216 = 1, t3l = 0, t3h = 0, t316 = 0, pin = 0;
    reg [9:0] vin = 10'h000;
    reg [31:0] ctl = 32'h0000_0000;
    reg [31:0] rd;
    reg [1:0] rr;
    wire awready, wready, bvalid, arready, rvalid, cmp, tick, track, pwr, ghalf, busy;
    wire [1:0] bresp, rresp, dem;
    wire [31:0] rdata;
    wire [9:0] trial;
    integer fails = 0;
    integer comparisons = 0;
    integer s;
    sac_top i_dut (
        .I_CLK(clk), .I_SYS_RST(rst), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
        .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wvalid),
        .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
        .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
        .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_T0_OVF(t0),
        .I_T2_LO_OVF(t2l), .I_T2_HI_OVF(t2h), .I_T2_16BIT(t216), .I_T3_LO_OVF(t3l),
        .I_T3_HI_OVF(t3h), .I_T3_16BIT(t316), .I_EXTERNAL_CONVERT_START(pin),
        .I_BURST_TICK(tick), .I_CMP(cmp), .O_DAC_TRIAL(trial), .O_DEM_PHASE(dem),
        .O_TRACK(track), .O_POWER_ON(pwr), .O_GAIN_HALF(ghalf), .O_SAR_BUSY(busy)
    );
    sac_analog_model u_far (
        .i_clk(clk), .i_burst_on(ctl[6]), .i_level(vin), .i_trial(trial), .o_cmp(cmp),
        .o_tick(tick)
    );
    initial begin
        forever #10 clk = ~clk;
    end
    task check(input [31:0] seen, input [31:0] exp, input [8*8:1] what);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("[FAIL] %0s exp %h seen %h", what, exp, seen);
            end
        end
    endtask
    task wrap_up;
        begin
            $display("fails %0d comparisons %0d", fails, comparisons);
            if (fails == 0 && comparisons > 0) begin
                $display("bench passed");
            end else begin
                $display("bench failed");
            end
            $finish;
        end
    endtask
    task lim;
        begin
            fails = fails + 1;
            wrap_up;
        end
    endtask
    // address and data go out together and are released at the edge that takes them
    task axw(input [7:0] a, input [31:0] d, input [1:0] er);
        integer n;
        begin
            awaddr <= a;
            wdata <= d;
            {awvalid, wvalid, bready} <= 3'h7;
            n = 0;
            @(posedge clk);
            while (awready !== 1'b1 && n < 50) begin
                @(posedge clk);
                n = n + 1;
            end
            {awvalid, wvalid} <= 2'h0;
            while (bvalid !== 1'b1 && n < 50) begin
                @(posedge clk);
                n = n + 1;
            end
            bready <= 1'b0;
            if (n >= 50) lim;
            check(bresp, er, "bresp");
            @(posedge clk);
        end
    endtask
    task axr(input [7:0] a);
        integer n;
        begin
            araddr <= a;
            {arvalid, rready} <= 2'h3;
            n = 0;
            @(posedge clk);
            while (rvalid !== 1'b1 && n < 50) begin
                @(posedge clk);
                n = n + 1;
            end
            {arvalid, rready} <= 2'h0;
            rd = rdata;
            rr = rresp;
            if (n >= 50) lim;
            @(posedge clk);
        end
    endtask
    task fire(input [2:0] src);
        begin
            case (src)
                // ones on the flag bits leave a flag that was set standing
                3'h0: axw(CT, ctl | 32'h0000_0038, OK);
                3'h1: t0 <= 1'b1;
                3'h2: t2h <= 1'b1;
                3'h3: t3l <= 1'b1;
                default: pin <= 1'b1;
            endcase
            @(posedge clk);
            {t0, t2h, t3l, pin} <= 4'h0;
            // starts stay four clocks apart
            repeat (3) @(posedge clk);
        end
    endtask
    task series(input [31:0] c, input [31:0] a, input integer k, input [31:0] exp);
        integer i, n;
        begin
            ctl = c;
            axw(AC, a, OK);
            axw(CT, c, OK);
            for (i = 0; i < k; i = i + 1) begin
                fire(c[2:0]);
                n = 0;
                while (busy === 1'b1 && n < 3000) begin
                    @(posedge clk);
                    n = n + 1;
                end
                if (n >= 3000) lim;
                if (i < k - 1) begin
                    axr(CT);
                    check(rd[5], 0, "early");
                end
            end
            n = 0;
            rd = 0;
            while (rd[5] !== 1'b1 && n < 900) begin
                axr(CT);
                n = n + 1;
            end
            if (n >= 900) lim;
            check(rd[4], 0, "busy");
            axr(`SAC_OFS_RESULT);
            check(rd, exp, "result");
        end
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        axr(CT);
        check(rd, 0, "ctrl");
        axr(`SAC_OFS_GT);
        check(rd, 32'h0000_FFFF, "gt");
        axr(8'h1C);
        check(rr, `SAC_RESP_SLVERR, "unmapped");
        axw(`SAC_OFS_RESULT, 32'h0000_1234, `SAC_RESP_SLVERR);
        axw(CF, 0, OK);
        check(ghalf, 1, "half");
        axw(CF, 1, OK);
        check(ghalf, 0, "one");
        axw(`SAC_OFS_TIMING, 32'h0000_0202, OK);
        axw(`SAC_OFS_GT, 32'h0000_0100, OK);
        axw(`SAC_OFS_LT, 32'h0000_0200, OK);
        vin = 10'h155;
        series(32'h0000_0080, 0, 1, 32'h0000_0155);
        axr(CT);
        check(rd[3], 1, "window");
        check(rd[5], 1, "kept");
        check(track, 1, "track");
        axw(CT, ctl, OK);
        axr(CT);
        check(rd[5], 0, "cleared");
        for (s = 1; s < 5; s = s + 1) begin
            series(32'h0000_0080 | s, 0, 1, 32'h0000_0155);
        end
        ctl = 32'h0000_0083;
        axw(CT, ctl, OK);
        t3h <= 1'b1;
        @(posedge clk);
        t3h <= 1'b0;
        repeat (4) @(posedge clk);
        check(busy, 0, "t3 high");
        series(32'h0000_0180, 0, 1, 32'h0000_0155);
        check(track, 0, "lp hold");
        series(32'h0000_0184, 0, 1, 32'h0000_0155);
        check(track, 1, "pin low");
        axw(CF, 32'h0000_0005, OK);
        vin = 10'h2AB;
        series(32'h0000_0080, 0, 1, 32'h0000_AA00);
        axw(CF, 1, OK);
        vin = 10'h155;
        axw(`SAC_OFS_GT, 32'h0000_02A0, OK);
        axw(`SAC_OFS_LT, 32'h0000_02B0, OK);
        series(32'h0000_0080, 1, 4, 32'h0000_0554);
        axr(CT);
        check(rd[3], 0, "partial");
        series(32'h0000_0040, 1, 1, 32'h0000_0554);
        repeat (8) @(posedge clk);
        check(pwr, 0, "idle off");
        series(32'h0000_00C0, 1, 1, 32'h0000_0554);
        check(pwr, 1, "idle on");
        series(32'h0000_0141, 1, 1, 32'h0000_0554);
        vin = 10'h3FF;
        series(32'h0000_0040, 32'h0000_0081, 1, 32'h0000_0FFC);
        series(32'h0000_0044, 32'h0000_0083, 1, 32'h0000_3FF0);
        wrap_up;
    end
endmodule // sac_top_tb
